//--- pkg/hbms_dec_if.sv
`timescale 1ns/100ps
// carries one host access from the top to the decoder and back
interface hbms_dec_if;
  import hbms_pkg::*;
  hbms_mode_t mode; // selected personality
  logic [HBMS_ADDR_W-1:0] addr; // host address
  logic [HBMS_ADDR_W-1:0] base; // i/o base from configuration
  logic qual_n; // address qualifier, low qualifies
  logic card_en_n; // card enable, pcmcia only
  logic rd_n; // read strobe pin
  logic wr_n; // write strobe pin
  logic hit; // access targets this device
  logic rd; // decoded read
  logic wr; // decoded write
  logic [HBMS_OFF_W-1:0] offset; // register index

  modport dec (
    input mode, addr, base, qual_n, card_en_n, rd_n, wr_n,
    output hit, rd, wr, offset
  );
  modport user (
    output mode, addr, base, qual_n, card_en_n, rd_n, wr_n,
    input hit, rd, wr, offset
  );
endinterface

//--- pkg/hbms_pkg.sv
// Function
// - mode chosen only at reset end, then held
// - strap low at reset end selects PCMCIA
// - strap high (pulled up) selects local bus
// - both strobes low at power-up with strap high selects alt bus
// - PCMCIA decode ignores upper address lines
// - same register layout in local and PCMCIA
// - EEPROM config fetched at reset, every mode
package hbms_pkg;
  // host bus personalities
  typedef enum logic [1:0] {
    HBMS_LOCAL,
    HBMS_PCMCIA,
    HBMS_ALT
  } hbms_mode_t;

  // eeprom fetch sequencer states
  typedef enum logic [1:0] {
    HBMS_EE_IDLE,
    HBMS_EE_WAIT,
    HBMS_EE_DONE
  } hbms_ee_t;

  localparam int HBMS_ADDR_W = 16; // host address width
  localparam int HBMS_OFF_W = 4; // 16 i/o locations
  localparam int HBMS_OFF_LSB = 0; // offset field position
  localparam hbms_mode_t HBMS_MODE_RST = HBMS_LOCAL; // reset mode
  localparam logic [HBMS_ADDR_W-1:0] HBMS_BASE_MASK = 16'hfff0;

  // base compare on the upper lines, used by two modes
  function automatic logic hbms_base_hit(
    input logic [HBMS_ADDR_W-1:0] addr,
    input logic [HBMS_ADDR_W-1:0] base
  );
    hbms_base_hit = ((addr ^ base) & HBMS_BASE_MASK) == 16'h0000;
  endfunction
endpackage

//--- rtl/hbms_decode.sv
`timescale 1ns/100ps
// maps host pins of each personality onto one register structure
module hbms_decode (
  hbms_dec_if.dec bus
);
  import hbms_pkg::*;

  // per-mode select and strobe decode
  always_comb begin
    bus.offset = bus.addr[HBMS_OFF_LSB +: HBMS_OFF_W];
    bus.hit = 1'b0;
    bus.rd = 1'b0;
    bus.wr = 1'b0;
    case (bus.mode)
      HBMS_LOCAL: begin
        // base window qualified by the address enable
        bus.hit = !bus.qual_n && hbms_base_hit(bus.addr, bus.base);
        bus.rd = bus.hit && !bus.rd_n;
        bus.wr = bus.hit && !bus.wr_n;
      end
      HBMS_PCMCIA: begin
        // socket decodes the slot, upper lines unused
        bus.hit = !bus.card_en_n;
        bus.rd = bus.hit && !bus.rd_n;
        bus.wr = bus.hit && !bus.wr_n;
      end
      HBMS_ALT: begin
        // read pin is data strobe, write pin is read-not-write
        bus.hit = !bus.qual_n && hbms_base_hit(bus.addr, bus.base);
        bus.rd = bus.hit && !bus.rd_n && bus.wr_n;
        bus.wr = bus.hit && !bus.rd_n && !bus.wr_n;
      end
      default: begin
        bus.hit = 1'b0;
      end
    endcase
  end
endmodule

//--- rtl/hbms_mode_sel.sv
`timescale 1ns/100ps
// host bus personality select and access decode
module hbms_mode_sel (
  input wire logic clk_in, // device clock
  input wire logic reset_in, // hardware reset, active high
  input wire logic por_in, // high when this reset is power-up
  input wire logic host_mode_strap_n_in, // low selects pcmcia
  input wire logic io_read_strobe_n_in, // read strobe pin
  input wire logic io_write_strobe_n_in, // write strobe pin
  input wire logic [hbms_pkg::HBMS_ADDR_W-1:0] host_addr_in,
  input wire logic [hbms_pkg::HBMS_ADDR_W-1:0] io_base_in,
  input wire logic addr_qual_n_in, // address qualifier
  input wire logic card_en_n_in, // pcmcia card enable
  input wire logic eeprom_done_in, // eeprom fetch finished
  output hbms_pkg::hbms_mode_t mode_out, // held personality
  output logic mode_valid_out, // mode decided
  output logic eeprom_fetch_out, // one-cycle fetch request
  output logic config_ready_out, // configuration loaded
  output logic reg_hit_out, // access to this device
  output logic reg_rd_out, // register read
  output logic reg_wr_out, // register write
  output logic [hbms_pkg::HBMS_OFF_W-1:0] reg_offset_out,
  output logic alt_seq_err_out // alt bus opened with a read
);
  import hbms_pkg::*;

  logic rst_seen_q; // set during reset, marks release edge
  logic first_acc_q; // no alt access seen yet
  logic acc_d; // any decoded access this cycle
  hbms_ee_t ee_q; // eeprom sequencer state
  hbms_dec_if dec (); // link to the decoder

  // drive the decoder from the pins and held mode
  assign dec.mode = mode_out;
  assign dec.addr = host_addr_in;
  assign dec.base = io_base_in;
  assign dec.qual_n = addr_qual_n_in;
  assign dec.card_en_n = card_en_n_in;
  assign dec.rd_n = io_read_strobe_n_in;
  assign dec.wr_n = io_write_strobe_n_in;
  assign acc_d = mode_valid_out && (dec.rd || dec.wr);

  // per-mode address and strobe decode
  hbms_decode u_decode (
    .bus(dec.dec)
  );

  // mode selection, decided once at the first edge after release
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode_out <= HBMS_MODE_RST;
      mode_valid_out <= 1'b0;
      rst_seen_q <= 1'b1;
    end else if (rst_seen_q) begin
      rst_seen_q <= 1'b0;
      mode_valid_out <= 1'b1;
      if (!host_mode_strap_n_in) begin
        // strap pulled low selects the card interface
        mode_out <= HBMS_PCMCIA;
      end else if (por_in && !io_read_strobe_n_in &&
                   !io_write_strobe_n_in) begin
        // both strobes held at power-up in local mode
        mode_out <= HBMS_ALT;
      end else begin
        // open strap with pull-up reads high
        mode_out <= HBMS_LOCAL;
      end
    end else begin
      mode_out <= mode_out;
    end
  end

  // eeprom fetch, identical in every mode
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ee_q <= HBMS_EE_IDLE;
      eeprom_fetch_out <= 1'b0;
      config_ready_out <= 1'b0;
    end else begin
      eeprom_fetch_out <= 1'b0;
      case (ee_q)
        HBMS_EE_IDLE: begin
          if (rst_seen_q) begin
            eeprom_fetch_out <= 1'b1;
            ee_q <= HBMS_EE_WAIT;
          end
        end
        HBMS_EE_WAIT: begin
          // wait for the serial loader to finish
          if (eeprom_done_in) begin
            config_ready_out <= 1'b1;
            ee_q <= HBMS_EE_DONE;
          end
        end
        HBMS_EE_DONE: begin
          config_ready_out <= 1'b1;
        end
        default: begin
          ee_q <= HBMS_EE_IDLE;
        end
      endcase
    end
  end

  // registered access outputs; hit and strobes blocked until the mode is known, offset always follows the address
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reg_hit_out <= 1'b0;
      reg_rd_out <= 1'b0;
      reg_wr_out <= 1'b0;
      reg_offset_out <= '0;
    end else begin
      reg_hit_out <= mode_valid_out && dec.hit;
      reg_rd_out <= mode_valid_out && dec.rd;
      reg_wr_out <= mode_valid_out && dec.wr;
      reg_offset_out <= dec.offset;
    end
  end

  // flags an alt-bus session whose first access is a read
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      first_acc_q <= 1'b1;
      alt_seq_err_out <= 1'b0;
    end else if (acc_d && first_acc_q && mode_out == HBMS_ALT) begin
      first_acc_q <= 1'b0;
      alt_seq_err_out <= dec.rd;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  AST_MODE_HOLD: assert property (
    mode_valid_out |=> $stable(mode_out) && mode_valid_out)
    else $error("mode changed outside reset");

  AST_STRAP_LOW: assert property (
    $fell(reset_in) && !host_mode_strap_n_in
      |=> mode_out == HBMS_PCMCIA)
    else $error("low strap did not give pcmcia");

  AST_STRAP_HIGH: assert property (
    $fell(reset_in) && host_mode_strap_n_in &&
    !(por_in && !io_read_strobe_n_in && !io_write_strobe_n_in)
      |=> mode_out == HBMS_LOCAL)
    else $error("high strap did not give local bus");

  AST_ALT_ENTRY: assert property (
    $fell(reset_in) && host_mode_strap_n_in && por_in &&
    !io_read_strobe_n_in && !io_write_strobe_n_in
      |=> mode_out == HBMS_ALT)
    else $error("strobes at power-up did not give alt bus");

  AST_PC_UPPER: assert property (
    mode_valid_out && mode_out == HBMS_PCMCIA && !card_en_n_in &&
    !io_read_strobe_n_in |=> reg_rd_out && reg_hit_out)
    else $error("pcmcia read missed by upper address");

  AST_ALT_ORDER: assert property (
    mode_out == HBMS_ALT && first_acc_q && acc_d && dec.rd
      |=> alt_seq_err_out [*2])
    else $error("alt read-first not flagged");

  AST_LAYOUT: assert property (
    reg_hit_out |-> reg_offset_out == $past(host_addr_in[3:0]))
    else $error("register offset not from low address");

  AST_EE_FETCH: assert property (
    $fell(reset_in) |=> eeprom_fetch_out ##1 !eeprom_fetch_out)
    else $error("eeprom fetch not issued once at reset end");

  AST_RESET_LOCAL: assert property (
    disable iff (1'b0)
    reset_in |=> mode_out == HBMS_LOCAL && !mode_valid_out)
    else $error("mode not local during reset");

  // no access reaches the register side before the mode is known
  AST_NO_EARLY_ACC: assert property (
    !mode_valid_out |=> !reg_hit_out && !reg_rd_out && !reg_wr_out)
    else $error("access decoded before mode was chosen");

  // the card enable alone selects the device in pcmcia mode
  AST_PC_CARD_EN: assert property (
    mode_valid_out && mode_out == HBMS_PCMCIA && card_en_n_in
      |=> !reg_hit_out)
    else $error("pcmcia access hit without card enable");

  // local write: qualified, upper lines on the base window
  AST_LOCAL_WR: assert property (
    mode_valid_out && mode_out == HBMS_LOCAL && !addr_qual_n_in &&
    host_addr_in[HBMS_ADDR_W-1:HBMS_OFF_W] ==
      io_base_in[HBMS_ADDR_W-1:HBMS_OFF_W] &&
    !io_write_strobe_n_in |=> reg_wr_out && reg_hit_out)
    else $error("local write not decoded");

  // alt write: data strobe low with read-not-write low
  AST_ALT_WR: assert property (
    mode_valid_out && mode_out == HBMS_ALT && !addr_qual_n_in &&
    host_addr_in[HBMS_ADDR_W-1:HBMS_OFF_W] ==
      io_base_in[HBMS_ADDR_W-1:HBMS_OFF_W] &&
    !io_read_strobe_n_in && !io_write_strobe_n_in
      |=> reg_wr_out && !reg_rd_out)
    else $error("alt write not decoded");

  // the read-first flag stays until the next reset
  AST_ERR_STICKY: assert property (
    alt_seq_err_out |=> alt_seq_err_out)
    else $error("alt order flag dropped");

  // the fetch request is a single-cycle pulse
  AST_FETCH_PULSE: assert property (
    eeprom_fetch_out |=> !eeprom_fetch_out)
    else $error("eeprom fetch request held too long");

  // loaded configuration stays ready until reset
  AST_CFG_HOLD: assert property (
    config_ready_out |=> config_ready_out)
    else $error("configuration ready dropped");

  // scenario coverage: each personality and the read-first case
  COV_PCMCIA: cover property (
    $fell(reset_in) ##1 mode_out == HBMS_PCMCIA ##[1:20] reg_wr_out);
  COV_ALT: cover property (
    mode_out == HBMS_ALT && reg_wr_out ##[1:20] reg_rd_out);
  COV_LOCAL_EE: cover property (
    mode_out == HBMS_LOCAL && eeprom_fetch_out ##[1:50] config_ready_out);
  COV_ALT_RD_FIRST: cover property (
    mode_out == HBMS_ALT && alt_seq_err_out);
endmodule

//--- verification/hbms_host_model.sv
`timescale 1ns/100ps
// host side of the bus: strobes, address, qualifiers
module hbms_host_model (
  input wire logic clk_in, // device clock
  output logic rd_n_out, // read or data strobe
  output logic wr_n_out, // write or read-not-write
  output logic [15:0] addr_out, // host address
  output logic qual_n_out, // address qualifier
  output logic cen_n_out // card enable
);
  // idle lines float high on their pull-ups
  initial begin
    {rd_n_out, wr_n_out, qual_n_out, cen_n_out} = 4'hf;
    addr_out = 16'h0000;
  end
  // strobe levels held across a reset
  task automatic hold(input logic r, input logic w);
    rd_n_out <= r;
    wr_n_out <= w;
  endtask
  // one access for one cycle, then released; alt writes open with
  // the data strobe and read-not-write low
  task automatic access(input logic [15:0] a, input logic r,
    input logic q, input logic ce, input logic alt);
    @(posedge clk_in);
    addr_out <= a;
    rd_n_out <= !(r || alt);
    wr_n_out <= r;
    qual_n_out <= q;
    cen_n_out <= ce;
    @(posedge clk_in);
    {rd_n_out, wr_n_out, qual_n_out, cen_n_out} <= 4'hf;
    addr_out <= ~a; // released address never repeats the last one
  endtask
endmodule

//--- verification/tb_hbms_mode_sel.sv
`timescale 1ns/100ps
// resets into each mode and checks the decode of host accesses
module tb_hbms_mode_sel;
  import hbms_pkg::*;
  logic clk_in = 1'b0; // device clock
  logic reset_in = 1'b1; // sync reset
  logic por_in = 1'b1; // power-up flag
  logic strap_n = 1'b1; // mode strap
  logic done_in = 1'b0; // eeprom loader done
  logic rd_n, wr_n, qual_n, cen_n; // host pins
  logic [15:0] addr; // host address
  hbms_mode_t mode; // held mode
  logic vld, fetch, cfg, hit, rd, wr, err; // design flags
  logic [3:0] off; // register index
  logic [6:0] expq[$]; // expected access results
  logic [31:0] seed = 32'h4b5a_d435; // xorshift state
  int bad_count = 0; // mismatches
  int n_tests = 0; // comparisons
  always #4 clk_in = ~clk_in; // 125 MHz
  hbms_host_model hbms_host_model_i (.clk_in(clk_in), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .addr_out(addr), .qual_n_out(qual_n),
    .cen_n_out(cen_n));
  hbms_mode_sel hbms_mode_sel_i (.clk_in(clk_in), .reset_in(reset_in),
    .por_in(por_in), .host_mode_strap_n_in(strap_n),
    .io_read_strobe_n_in(rd_n), .io_write_strobe_n_in(wr_n),
    .host_addr_in(addr), .io_base_in(16'h0340),
    .addr_qual_n_in(qual_n), .card_en_n_in(cen_n),
    .eeprom_done_in(done_in), .mode_out(mode), .mode_valid_out(vld),
    .eeprom_fetch_out(fetch), .config_ready_out(cfg),
    .reg_hit_out(hit), .reg_rd_out(rd), .reg_wr_out(wr),
    .reg_offset_out(off), .alt_seq_err_out(err));
  // xorshift source for addresses and waits
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // status value compare
  task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // access result compare
  task automatic chk_acc(input logic [6:0] g, input logic [6:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // takes the oldest note whenever an access result shows
  always @(negedge clk_in) begin
    if ((hit | rd | wr) !== 1'b0) begin
      if (expq.size() == 0) chk_acc({hit, rd, wr, off}, 7'h00);
      else chk_acc({hit, rd, wr, off}, expq.pop_front());
    end
  end
  // reset with given pins, check the mode chosen and the eeprom fetch
  task automatic boot(input logic s, input logic p, input logic r,
    input logic w, input hbms_mode_t m);
    @(posedge clk_in);
    reset_in <= 1'b1;
    strap_n <= s;
    por_in <= p;
    hbms_host_model_i.hold(r, w);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk_val(8'(mode), 8'(HBMS_MODE_RST));
    chk_val({7'h0, vld}, 8'h00);
    @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    @(negedge clk_in);
    chk_val({5'h0, vld, fetch, cfg}, 8'h06);
    chk_val(8'(mode), 8'(m));
    @(posedge clk_in);
    hbms_host_model_i.hold(1'b1, 1'b1);
    strap_n <= ~s;
    @(negedge clk_in);
    chk_val({7'h0, fetch}, 8'h00);
    repeat (rnd() % 4) @(negedge clk_in);
    chk_val({7'h0, cfg}, 8'h00);
    @(posedge clk_in);
    done_in <= 1'b1;
    @(posedge clk_in);
    done_in <= 1'b0;
    @(negedge clk_in);
    chk_val({7'h0, cfg}, 8'h01);
    chk_val(8'(mode), 8'(m));
  endtask
  // host access with its expected result noted first
  task automatic acc(input logic [15:0] a, input logic r, input logic q,
    input logic ce, input logic alt, input logic ok);
    if (ok) expq.push_back({1'b1, r, !r, a[3:0]});
    hbms_host_model_i.access(a, r, q, ce, alt);
  endtask
  initial begin
    logic [15:0] a;
    boot(1'b1, 1'b1, 1'b1, 1'b1, HBMS_LOCAL);
    for (int i = 0; i < 4; i++) begin
      a = {12'h034, 4'(rnd())};
      acc(a, i[0], 1'b0, 1'b1, 1'b0, 1'b1);
      acc(a, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      acc(a ^ 16'h1000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    end
    $display("test local done");
    boot(1'b0, 1'b1, 1'b0, 1'b0, HBMS_PCMCIA);
    for (int i = 0; i < 4; i++) begin
      a = 16'(rnd());
      acc(a, i[0], 1'b1, 1'b0, 1'b0, 1'b1);
      acc(a, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    end
    $display("test pcmcia done");
    boot(1'b1, 1'b0, 1'b0, 1'b0, HBMS_LOCAL);
    boot(1'b1, 1'b1, 1'b0, 1'b0, HBMS_ALT);
    acc(16'h0345, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    acc(16'h034a, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    repeat (2) @(negedge clk_in);
    chk_val({7'h0, err}, 8'h00);
    boot(1'b1, 1'b1, 1'b0, 1'b0, HBMS_ALT);
    acc(16'h0343, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    repeat (2) @(negedge clk_in);
    chk_val({7'h0, err}, 8'h01);
    $display("test alt done");
    repeat (3) @(negedge clk_in);
    chk_val(8'(expq.size()), 8'h00);
    tally_and_finish();
  end
  // cuts a hang short
  initial begin
    #40000;
    bad_count++;
    tally_and_finish();
  end
  // counts and verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
endmodule
